// ---- testbench/spi_master_model.sv ----
`timescale 1ns/1ps
module spi_master_model
(
    // System clock that paces the pins
    input wire logic clock,
    // Pins toward the device
    output logic sclk,
    output logic select_n,
    output logic hold_n,
    output logic serial_data_in,
    // Pins from the device
    input wire logic serial_data_out,
    input wire logic serial_data_out_en
);
    // Idle clock level, high in mode three
    logic mode3;
    // Output enable seen inside the last hold pause
    logic hold_en;

    // Idle pins at time zero
    initial
    begin
        mode3 = 1'b0;
        hold_en = 1'b1;
        sclk = 1'b0;
        select_n = 1'b1;
        hold_n = 1'b1;
        serial_data_in = 1'b0;
    end

    // Waits whole system clocks, ending at a falling edge
    task automatic pause(input int n);
        repeat (n) @(negedge clock);
    endtask

    // Picks the clock mode and parks the clock at its idle level
    task automatic set_mode(input logic m);
        mode3 = m;
        sclk = m;
        pause(5);
    endtask

    // Select or release; a released data line shows the inverse level
    task automatic sel(input logic v);
        pause(5);
        select_n = v;
        if (v)
            serial_data_in = ~serial_data_in;
        pause(5);
    endtask

    // Hold pause with clock and data moving, entered and left with clock low
    task automatic do_hold();
        hold_n = 1'b0;
        pause(5);
        hold_en = serial_data_out_en;
        repeat (2)
        begin
            sclk = 1'b1;
            serial_data_in = ~serial_data_in;
            pause(5);
            sclk = 1'b0;
            pause(5);
        end
        hold_n = 1'b1;
        pause(5);
    endtask

    // One byte MSB first; data set while the clock is low, output taken at the rise
    task automatic xfer(input logic [7:0] tx, input int hold_at, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--)
        begin
            sclk = 1'b0;
            serial_data_in = tx[i];
            pause(5);
            if (i == hold_at)
                do_hold();
            // An undriven line reads as the inverse of the last driven bit
            rx[i] = serial_data_out_en ? serial_data_out : ~serial_data_out;
            sclk = 1'b1;
            pause(5);
        end
        sclk = mode3;
        pause(5);
    endtask
endmodule

// ---- testbench/tb_serial_flash_pin_interface.sv ----
`timescale 1ns/1ps
module tb_serial_flash_pin_interface;
    import flash_pins_pkg::*;
    // Pins, byte ports and status
    logic clock, nrst, sclk, select_n, hold_n, wp_n, serial_data_in;
    logic serial_data_out, serial_data_out_en, rx_strobe, rx_first, tx_valid, tx_ready;
    logic busy, protect_wr, hold_active, armed, hold_seen;
    logic [7:0] rx_byte, tx_data, got;
    logic [2:0] protect_wr_data, protect_level_bits;
    power_state_t power_state;
    int error_cnt = 0;
    int n_compared = 0;
    // Received bytes with their first flag on top
    logic [8:0] rxq[$];

    serial_flash_pin_interface dut (.clock(clock), .nrst(nrst), .sclk(sclk),
        .select_n(select_n), .hold_n(hold_n), .wp_n(wp_n), .serial_data_in(serial_data_in),
        .serial_data_out(serial_data_out), .serial_data_out_en(serial_data_out_en),
        .rx_byte(rx_byte), .rx_strobe(rx_strobe), .rx_first(rx_first), .tx_valid(tx_valid),
        .tx_data(tx_data), .tx_ready(tx_ready), .busy(busy), .protect_wr(protect_wr),
        .protect_wr_data(protect_wr_data), .protect_level_bits(protect_level_bits),
        .power_state(power_state), .hold_active(hold_active), .armed(armed));
    spi_master_model master (.clock(clock), .sclk(sclk), .select_n(select_n), .hold_n(hold_n),
        .serial_data_in(serial_data_in), .serial_data_out(serial_data_out),
        .serial_data_out_en(serial_data_out_en));

    // Clock of 100 ns
    initial
    begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    // Collects every received byte, sampled between edges
    always @(negedge clock)
        if (rx_strobe === 1'b1)
            rxq.push_back({rx_first, rx_byte});

    // Compares one value
    task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] seen);
        n_compared++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Pushes one byte into the outgoing buffer
    task automatic push(input logic [7:0] b);
        @(negedge clock);
        tx_valid = 1'b1;
        tx_data = b;
        @(posedge clock);
        while (tx_ready !== 1'b1)
            @(posedge clock);
        @(negedge clock);
        tx_valid = 1'b0;
    endtask

    // Requests a protect level load
    task automatic wrp(input logic [2:0] v);
        protect_wr = 1'b1;
        protect_wr_data = v;
        master.pause(1);
        protect_wr = 1'b0;
        master.pause(3);
    endtask

    // Traffic before the first select, then the first select
    task automatic t_arm();
        chk("armed", 0, armed);
        master.xfer(8'h5A, -1, got);
        chk("strobes", 0, rxq.size());
        chk("en idle", 0, serial_data_out_en);
        master.sel(1'b0);
        chk("armed", 1, armed);
        chk("power", ST_ACTIVE, power_state);
        chk("en", 1, serial_data_out_en);
    endtask

    // Two bytes in, command flag on the first only; one byte out in mode zero
    task automatic t_rx();
        push(8'h69);
        master.xfer(8'hA5, -1, got);
        master.xfer(8'h3C, -1, got);
        chk("tx mode0", 8'h69, got);
        chk("rx count", 2, rxq.size());
        chk("rx0", 9'h1A5, rxq.pop_front());
        chk("rx1", 9'h03C, rxq.pop_front());
        master.sel(1'b1);
        chk("en off", 0, serial_data_out_en);
        chk("power", ST_STANDBY, power_state);
    endtask

    // Busy keeps the device active; hold while deselected is refused
    task automatic t_busy();
        busy = 1'b1;
        master.sel(1'b0);
        master.sel(1'b1);
        chk("power busy", ST_ACTIVE, power_state);
        busy = 1'b0;
        master.pause(3);
        chk("power idle", ST_STANDBY, power_state);
        fork
            master.do_hold();
            begin
                master.pause(4);
                hold_seen = hold_active;
            end
        join
        chk("hold desel", 0, hold_seen);
    endtask

    // Hold in mid byte, the byte still arrives whole
    task automatic t_hold();
        rxq.delete();
        master.hold_en = 1'b1;
        master.sel(1'b0);
        fork
            master.xfer(8'h96, 4, got);
            begin
                master.pause(46);
                hold_seen = hold_active;
            end
        join
        chk("hold on", 1, hold_seen);
        chk("hold en", 0, master.hold_en);
        chk("rx held", 9'h196, rxq.pop_front());
        master.sel(1'b1);
    endtask

    // Fill the buffer, then read it out in mode three
    task automatic t_tx();
        for (int i = 0; i < TX_DEPTH; i++)
            push(8'h10 + 8'(i));
        master.pause(1);
        chk("full", 0, tx_ready);
        master.set_mode(1'b1);
        master.sel(1'b0);
        for (int i = 0; i < TX_DEPTH; i++)
        begin
            master.xfer(8'h00, -1, got);
            chk("tx", 8'h10 + 8'(i), got);
        end
        master.xfer(8'h00, -1, got);
        chk("tx empty", IDLE_BYTE, got);
        chk("ready", 1, tx_ready);
        master.sel(1'b1);
        master.set_mode(1'b0);
    endtask

    // Protect level loads with write protect off and on
    task automatic t_protect();
        wrp(3'h5);
        chk("protect", 3'h5, protect_level_bits);
        wp_n = 1'b0;
        master.pause(4);
        wrp(3'h2);
        chk("protect frozen", 3'h5, protect_level_bits);
        wp_n = 1'b1;
        master.pause(4);
        wrp(3'h2);
        chk("protect", 3'h2, protect_level_bits);
    endtask

    // Reset in mid run: disarmed again until the next select edge
    task automatic t_reset();
        nrst = 1'b0;
        master.pause(2);
        nrst = 1'b1;
        master.pause(2);
        chk("armed rst", 0, armed);
        chk("en rst", 0, serial_data_out_en);
        chk("power rst", ST_STANDBY, power_state);
        chk("protect rst", PROTECT_RESET, protect_level_bits);
        chk("ready rst", 1, tx_ready);
        rxq.delete();
        master.xfer(8'hE7, -1, got);
        chk("strobes rst", 0, rxq.size());
        master.sel(1'b0);
        chk("armed sel", 1, armed);
        master.sel(1'b1);
    endtask

    // Prints the counts and the verdict
    task automatic results();
        $display("Compared %0d, errors %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Main sequence
    initial
    begin
        nrst = 1'b0;
        wp_n = 1'b1;
        tx_valid = 1'b0;
        tx_data = 8'h00;
        busy = 1'b0;
        protect_wr = 1'b0;
        protect_wr_data = 3'h0;
        repeat (6) @(posedge clock);
        @(negedge clock);
        nrst = 1'b1;
        master.pause(2);
        t_arm();
        t_rx();
        t_busy();
        t_hold();
        t_tx();
        t_protect();
        t_reset();
        results();
    end

    // Watchdog against a hang
    initial
    begin
        repeat (20000) @(posedge clock);
        error_cnt++;
        results();
    end
endmodule

// ---- verilog/byte_fifo.sv ----
`timescale 1ns/1ps
module byte_fifo
    import flash_pins_pkg::*;
#(
    parameter int WIDTH = BYTE_W,
    parameter int DEPTH = TX_DEPTH
)
(
    // Clock and reset
    input wire logic clock,
    input wire logic nrst,
    // Filling side
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    // Draining side
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);

    localparam int AW = $clog2(DEPTH);

    // Entry storage
    logic [WIDTH-1:0] mem [DEPTH];
    // Pointers and fill count
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic [AW:0] next_count;
    logic push;
    logic pop;

    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;
    assign out_data = mem[rd_ptr];

    // Next fill level from this cycle's push and pop
    always_comb
    begin
        next_count = count;
        if (push && !pop)
        begin
            next_count = count + (AW+1)'(1);
        end
        else if (pop && !push)
        begin
            next_count = count - (AW+1)'(1);
        end
    end

    // Entry writes
    always_ff @(posedge clock)
    begin
        if (push)
        begin
            mem[wr_ptr] <= in_data;
        end
    end

    // Pointers, count and registered flags
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
            in_ready <= 1'b0;
            out_valid <= 1'b0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + AW'(1);
            end
            if (pop)
            begin
                rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + AW'(1);
            end
            count <= next_count;
            in_ready <= (next_count != (AW+1)'(DEPTH));
            out_valid <= (next_count != '0);
        end
    end

endmodule

// ---- verilog/flash_pins_pkg.sv ----
package flash_pins_pkg;

    // Width of one serial byte
    localparam int BYTE_W = 8;
    // Depth of the outgoing byte buffer
    localparam int TX_DEPTH = 8;
    // Width of the protect level field
    localparam int PROTECT_W = 3;
    // Reset value of the protect level field
    localparam logic [2:0] PROTECT_RESET = 3'h0;
    // Byte shifted out when no outgoing byte is waiting
    localparam logic [7:0] IDLE_BYTE = 8'hFF;
    // Bit counter value of the last bit in a byte
    localparam logic [2:0] LAST_BIT = 3'h7;

    // Power state seen from outside
    typedef enum logic [0:0] {
        ST_STANDBY = 1'b0,
        ST_ACTIVE = 1'b1
    } power_state_t;

    // Pin levels, raw or synchronised
    typedef struct packed {
        logic sclk;
        logic select_n;
        logic hold_n;
        logic wp_n;
        logic data_in;
    } pins_t;

    // Received byte with its strobe
    typedef struct packed {
        logic strobe;
        logic [7:0] data;
    } rx_word_t;

endpackage

// ---- verilog/serial_flash_pin_interface.sv ----
// Behaviour
// - Sample serial input on each rising clock edge
// - Input carries command, address, then program data
// - Change serial output after each falling edge
// - Select high: deselected, ignore traffic, output floats
// - Deselected: standby once internal cycle has finished
// - Select low enables device, active power state
// - Ignore commands until first select falling edge
// - Hold low pauses transfer, resumes where stopped
// - During hold output floats, clock, input ignored
// - Hold valid only while select is low
// - Write protect low freezes protect level bits
// - Works in clock modes zero and three
`timescale 1ns/1ps
module serial_flash_pin_interface
    import flash_pins_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic nrst,
    // Serial pins from the bus master
    input wire logic sclk,
    input wire logic select_n,
    input wire logic hold_n,
    input wire logic wp_n,
    input wire logic serial_data_in,
    // Serial output pin and its enable
    output logic serial_data_out,
    output logic serial_data_out_en,
    // Received bytes toward the command logic
    output logic [7:0] rx_byte,
    output logic rx_strobe,
    output logic rx_first,
    // Outgoing bytes from the command logic
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    output logic tx_ready,
    // Internal cycle status and protect level update
    input wire logic busy,
    input wire logic protect_wr,
    input wire logic [2:0] protect_wr_data,
    // State seen by the rest of the device
    output logic [2:0] protect_level_bits,
    output power_state_t power_state,
    output logic hold_active,
    output logic armed
);

    // Two-stage synchronisers for the pins
    pins_t pin_raw;
    pins_t pin_m;
    pins_t pin_s;
    // Previous synchronised clock and select
    logic sclk_q;
    logic select_q;
    // Edge strobes on the serial clock
    logic rise;
    logic fall;
    // Transfer allowed this cycle
    logic xfer;
    // Bit position within the current byte
    logic [2:0] bit_cnt;
    // Input and output shift registers
    logic [7:0] rx_shift;
    logic [7:0] tx_shift;
    // First byte of the current selection not yet delivered
    logic first_pending;
    // Buffered outgoing byte
    logic buf_valid;
    logic [7:0] buf_data;
    logic buf_pop;

    assign pin_raw = {sclk, select_n, hold_n, wp_n, serial_data_in};

    for (genvar gi = 0; gi < $bits(pins_t); gi++)
    begin : g_sync
        // Each pin passes two flops before any logic reads it
        always_ff @(posedge clock or negedge nrst)
        begin
            if (!nrst)
            begin
                pin_m[gi] <= 1'b1;
                pin_s[gi] <= 1'b1;
            end
            else
            begin
                pin_m[gi] <= pin_raw[gi];
                pin_s[gi] <= pin_m[gi];
            end
        end
    end

    // Clock edges are ignored while deselected, unarmed or held
    assign rise = pin_s.sclk & ~sclk_q;
    assign fall = ~pin_s.sclk & sclk_q;
    assign xfer = ~pin_s.select_n & armed & ~hold_active;
    assign buf_pop = fall & xfer & (bit_cnt == 3'h0);

    // Outgoing byte buffer, drained one byte per byte boundary
    byte_fifo #(
        .WIDTH(BYTE_W),
        .DEPTH(TX_DEPTH)
    ) u_tx_fifo (
        .clock(clock),
        .nrst(nrst),
        .in_valid(tx_valid),
        .in_data(tx_data),
        .in_ready(tx_ready),
        .out_valid(buf_valid),
        .out_data(buf_data),
        .out_ready(buf_pop)
    );

    // Edge history of clock and select, and the registered output enable
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            sclk_q <= 1'b1; // Same level as the synchroniser reset: no false edge
            select_q <= 1'b1;
            serial_data_out_en <= 1'b0;
        end
        else
        begin
            sclk_q <= pin_s.sclk;
            select_q <= pin_s.select_n;
            // Drive only when selected, armed and not held
            serial_data_out_en <= xfer;
        end
    end

    // Armed by the first select falling edge after reset
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            armed <= 1'b0;
        end
        else if (select_q && !pin_s.select_n)
        begin
            armed <= 1'b1;
        end
    end

    // Hold pause, only while selected and with the clock low
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            hold_active <= 1'b0;
        end
        else if (pin_s.select_n)
        begin
            hold_active <= 1'b0;
        end
        else if (!pin_s.sclk)
        begin
            hold_active <= ~pin_s.hold_n;
        end
    end

    // Input shifting on rising edges, byte delivery
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            bit_cnt <= 3'h0;
            rx_shift <= 8'h00;
            rx_byte <= 8'h00;
            rx_strobe <= 1'b0;
            rx_first <= 1'b0;
            first_pending <= 1'b1;
        end
        else
        begin
            rx_strobe <= 1'b0;
            if (pin_s.select_n)
            begin
                // Deselect aborts any partial byte
                bit_cnt <= 3'h0;
                first_pending <= 1'b1;
            end
            else if (rise && xfer)
            begin
                rx_shift <= {rx_shift[6:0], pin_s.data_in};
                bit_cnt <= bit_cnt + 3'h1;
                if (bit_cnt == LAST_BIT)
                begin
                    // Command byte first, then address and data bytes
                    rx_byte <= {rx_shift[6:0], pin_s.data_in};
                    rx_strobe <= 1'b1;
                    rx_first <= first_pending;
                    first_pending <= 1'b0;
                end
            end
        end
    end

    // Output shifting on falling edges; works for both idle clock levels
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            tx_shift <= IDLE_BYTE;
            serial_data_out <= 1'b1;
        end
        else if (fall && xfer)
        begin
            if (bit_cnt == 3'h0)
            begin
                // Byte boundary: load the next buffered byte
                tx_shift <= buf_valid ? buf_data : IDLE_BYTE;
                serial_data_out <= buf_valid ? buf_data[7] : IDLE_BYTE[7];
            end
            else
            begin
                tx_shift <= {tx_shift[6:0], 1'b1};
                serial_data_out <= tx_shift[6];
            end
        end
    end

    // Power state follows select and internal cycles
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            power_state <= ST_STANDBY;
        end
        else
        begin
            case (power_state)
                ST_STANDBY:
                begin
                    if (!pin_s.select_n || busy)
                    begin
                        power_state <= ST_ACTIVE;
                    end
                end
                ST_ACTIVE:
                begin
                    if (pin_s.select_n && !busy)
                    begin
                        power_state <= ST_STANDBY;
                    end
                end
            endcase
        end
    end

    // Protect level bits, frozen while write protect is low
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            protect_level_bits <= PROTECT_RESET;
        end
        else if (protect_wr && pin_s.wp_n)
        begin
            protect_level_bits <= protect_wr_data;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    chk_sample_rising: assert property ((rise && xfer && bit_cnt == 3'h7) |=>
        (rx_strobe && rx_byte[0] == $past(pin_s.data_in)))
        else $error("byte not delivered on eighth rising edge");
    chk_byte_order_first: assert property ((rx_strobe && rx_first) |->
        $past(first_pending))
        else $error("first byte flag wrong");
    chk_out_on_fall: assert property ($changed(serial_data_out) |-> $past(fall && xfer))
        else $error("output changed off a falling edge");
    chk_deselect_float: assert property (pin_s.select_n |=> !serial_data_out_en)
        else $error("output driven while deselected");
    chk_standby_entry: assert property ((pin_s.select_n && !busy) |=>
        power_state == ST_STANDBY)
        else $error("no standby after deselect");
    chk_busy_active: assert property (busy |=> power_state == ST_ACTIVE)
        else $error("standby during internal cycle");
    chk_select_active: assert property (!pin_s.select_n |=> power_state == ST_ACTIVE)
        else $error("not active while selected");
    chk_unarmed_quiet: assert property (!armed |-> (!rx_strobe && !serial_data_out_en))
        else $error("traffic before first select edge");
    chk_hold_freeze: assert property ((hold_active && rise && !pin_s.select_n) |=>
        $stable(bit_cnt) ##1 !serial_data_out_en)
        else $error("bits counted during hold");
    chk_hold_float: assert property (hold_active |=> !serial_data_out_en)
        else $error("output driven during hold");
    chk_hold_selected: assert property (pin_s.select_n |=> !hold_active)
        else $error("hold while deselected");
    chk_wp_freeze: assert property (!pin_s.wp_n |=> $stable(protect_level_bits))
        else $error("protect bits changed under write protect");
    chk_hold_clock_low: assert property ($changed(hold_active) |-> $past(!pin_s.sclk ||
        pin_s.select_n))
        else $error("hold changed while clock high");

endmodule
